// File: jcs_pkg.sv
// constants for the jog / crawl / contactor sequencer
// assumes a 50 MHz control clock
package jcs_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned COAST_DROP_MS   = 100;
    localparam int unsigned LOCKOUT_MS      = 2000;
    localparam int unsigned COAST_DROP_CYC  = CLK_HZ / 1000 * COAST_DROP_MS;
    localparam int unsigned LOCKOUT_CYC     = CLK_HZ / 1000 * LOCKOUT_MS;
    // jog/slack ramp time in tenths of a second
    localparam int unsigned JOG_RAMP_MIN    = 1;
    localparam int unsigned JOG_RAMP_MAX    = 6000;
    localparam int unsigned JOG_RAMP_DFLT   = 10;
    localparam int unsigned SPEED_FULL      = 10000; // 100.00 percent
    localparam int unsigned DELAY_W         = 32;

    typedef enum logic [2:0] {
        MODE_STOP, MODE_RUN, MODE_CRAWL, MODE_SLACK1,
        MODE_SLACK2, MODE_JOG1, MODE_JOG2
    } op_mode_e;

    typedef enum logic [1:0] {
        RAMP_STOP, RAMP_RUN, RAMP_JOG
    } ramp_sel_e;

    typedef enum logic [1:0] {
        REF_BASE, REF_PLUS_SLACK, REF_JOG, REF_CRAWL
    } ref_sel_e;
endpackage

// File: jog_crawl_contactor_sequencer.sv
// jog / crawl / slack mode decode and main contactor sequencer
// assumes all inputs synchronous to ref_clk_in; the ramp and speed loop
// are outside and report speed, stop done and interlock state here
//
// Contract
// - selection input low/high picks option
// - stop, run and crawl decode
// - jog and slack decode, jog ramp
// - jog ramp time clamped, overrides others
// - one jog time for all directions
// - contactor needs ready, coast high, demand
// - run needs run input and interlock
// - drop contactor 100 ms after fault
// - interlock timeout drops contactor, lockout
// - release contactor after stop sequence
// - restart during drop-out clears delay
// - stop time limit starts on start low
// - delay starts at drop-out speed
// - run low while stopping or in delay releases contactor at once
// - loops inhibited during delay unless live
// - jog flag held until ramp settles
`timescale 1ns/10ps
module jog_crawl_contactor_sequencer #(
    parameter int unsigned COAST_DROP_CYC = jcs_pkg::COAST_DROP_CYC,
    parameter int unsigned LOCKOUT_CYC    = jcs_pkg::LOCKOUT_CYC
) (
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        start_in,
    input  wire logic        jog_in,
    input  wire logic        select_in,
    input  wire logic        run_in,
    input  wire logic        coast_halt_input_in,
    input  wire logic        ready_in,
    input  wire logic        zero_ilock_en_in,
    input  wire logic        zero_ilock_ok_in,
    input  wire logic        live_delay_in,
    input  wire logic        stop_done_in,
    input  wire logic        ramp_settled_in,
    input  wire logic [13:0] speed_abs_in,
    input  wire logic [13:0] dropout_speed_in,
    input  wire logic [31:0] dropout_delay_cyc_in,
    input  wire logic [12:0] jog_ramp_in,
    output logic             contactor_out,
    output logic             drive_run_out,
    output logic             loop_inhibit_out,
    output logic             lockout_out,
    output logic             jog_flag_out,
    output logic             slack_flag_out,
    output logic             stop_limit_start_out,
    output logic [2:0]       mode_out,
    output logic [1:0]       ramp_sel_out,
    output logic [1:0]       ref_sel_out,
    output logic [12:0]      ramp_time_out
);
    // ============================================================
    // input sampling
    // sampled inputs
    logic start_r, jog_r, sel_r, run_r, coast_r, ready_r;
    logic start_d_r;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_r   <= 1'b0;
            jog_r     <= 1'b0;
            sel_r     <= 1'b0;
            run_r     <= 1'b0;
            coast_r   <= 1'b0;
            ready_r   <= 1'b0;
            start_d_r <= 1'b0;
        end else begin
            start_r   <= start_in;
            jog_r     <= jog_in;
            sel_r     <= select_in;
            run_r     <= run_in;
            coast_r   <= coast_halt_input_in;
            ready_r   <= ready_in;
            start_d_r <= start_r;
        end
    end

    // ============================================================
    // mode decode
    jcs_pkg::op_mode_e mode_nxt;
    always_comb begin
        case ({start_r, jog_r, sel_r})
            3'b100:  mode_nxt = jcs_pkg::MODE_RUN;
            3'b101:  mode_nxt = jcs_pkg::MODE_CRAWL;
            3'b110:  mode_nxt = jcs_pkg::MODE_SLACK1;
            3'b111:  mode_nxt = jcs_pkg::MODE_SLACK2;
            3'b010:  mode_nxt = jcs_pkg::MODE_JOG1;
            3'b011:  mode_nxt = jcs_pkg::MODE_JOG2;
            default: mode_nxt = jcs_pkg::MODE_STOP;
        endcase
    end

    wire demand     = start_r | jog_r;
    wire jog_mode   = jog_r;
    wire [12:0] jog_clamped =
        (jog_ramp_in < 13'(jcs_pkg::JOG_RAMP_MIN)) ?
            13'(jcs_pkg::JOG_RAMP_MIN) :
        (jog_ramp_in > 13'(jcs_pkg::JOG_RAMP_MAX)) ?
            13'(jcs_pkg::JOG_RAMP_MAX) : jog_ramp_in;

    // ramp family of the last demand, held while demand is low; nothing reads it
    logic was_jog_r;
    // ramp / reference selection outputs
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_out      <= 3'(jcs_pkg::MODE_STOP);
            ramp_sel_out  <= 2'(jcs_pkg::RAMP_STOP);
            ref_sel_out   <= 2'(jcs_pkg::REF_BASE);
            ramp_time_out <= 13'(jcs_pkg::JOG_RAMP_DFLT);
            was_jog_r     <= 1'b0;
        end else begin
            mode_out <= 3'(mode_nxt);
            if (demand)
                was_jog_r <= jog_mode;
            ramp_time_out <= jog_clamped;
            if (jog_mode)
                ramp_sel_out <= 2'(jcs_pkg::RAMP_JOG);
            else if (start_r)
                ramp_sel_out <= 2'(jcs_pkg::RAMP_RUN);
            else
                ramp_sel_out <= 2'(jcs_pkg::RAMP_STOP);
            case (mode_nxt)
                jcs_pkg::MODE_SLACK1, jcs_pkg::MODE_SLACK2:
                    ref_sel_out <= 2'(jcs_pkg::REF_PLUS_SLACK);
                jcs_pkg::MODE_JOG1, jcs_pkg::MODE_JOG2:
                    ref_sel_out <= 2'(jcs_pkg::REF_JOG);
                jcs_pkg::MODE_CRAWL:
                    ref_sel_out <= 2'(jcs_pkg::REF_CRAWL);
                default:
                    ref_sel_out <= 2'(jcs_pkg::REF_BASE);
            endcase
        end
    end

    // ============================================================
    // contactor state machine
    typedef enum logic [2:0] {
        ST_OFF, ST_ON, ST_STOPPING, ST_DELAY, ST_FAULT_DROP, ST_LOCKOUT
    } con_state_e;
    con_state_e state_r;
    logic [31:0] cnt_r;
    wire healthy = ready_r & coast_r;
    wire ilock_bad = zero_ilock_en_in & ~zero_ilock_ok_in;
    wire at_drop = (speed_abs_in <= dropout_speed_in) ||
                   (dropout_speed_in >= 14'(jcs_pkg::SPEED_FULL));

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= ST_OFF;
            cnt_r   <= 32'h0000_0000;
        end else begin
            case (state_r)
                ST_OFF: begin
                    cnt_r <= 32'h0000_0000;
                    if (healthy && demand)
                        state_r <= ST_ON;
                end
                ST_ON: begin
                    if (ilock_bad)
                        cnt_r <= cnt_r + 32'h0000_0001;
                    else
                        cnt_r <= 32'h0000_0000;
                    if (!healthy) begin
                        state_r <= ST_FAULT_DROP;
                        cnt_r   <= 32'h0000_0000;
                    end else if (ilock_bad &&
                                 cnt_r >= 32'(LOCKOUT_CYC - 1)) begin
                        state_r <= ST_LOCKOUT;
                    end else if (!demand) begin
                        state_r <= ST_STOPPING;
                        cnt_r   <= 32'h0000_0000;
                    end
                end
                ST_STOPPING: begin
                    if (!healthy)
                        state_r <= ST_FAULT_DROP;
                    else if (!run_r)
                        state_r <= ST_OFF;
                    else if (demand)
                        state_r <= ST_ON;
                    else if (at_drop)
                        state_r <= ST_DELAY;
                    cnt_r <= 32'h0000_0000;
                end
                ST_DELAY: begin
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (!healthy) begin
                        state_r <= ST_FAULT_DROP;
                        cnt_r   <= 32'h0000_0000;
                    end else if (!run_r) begin
                        state_r <= ST_OFF;
                    end else if (demand) begin
                        state_r <= ST_ON;
                        cnt_r   <= 32'h0000_0000;
                    end else if (cnt_r >= dropout_delay_cyc_in &&
                                 stop_done_in) begin
                        state_r <= ST_OFF;
                    end
                end
                ST_FAULT_DROP: begin
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (cnt_r >= 32'(COAST_DROP_CYC - 1))
                        state_r <= ST_OFF;
                end
                ST_LOCKOUT: begin
                    cnt_r <= 32'h0000_0000;
                    if (!demand)
                        state_r <= ST_OFF;
                end
                default: state_r <= ST_OFF;
            endcase
        end
    end

    logic live_r;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            live_r <= 1'b0;
        else if (state_r != ST_DELAY)
            live_r <= live_delay_in;
    end

    // ============================================================
    // registered outputs
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            contactor_out        <= 1'b0;
            drive_run_out        <= 1'b0;
            loop_inhibit_out     <= 1'b1;
            lockout_out          <= 1'b0;
            jog_flag_out         <= 1'b0;
            slack_flag_out       <= 1'b0;
            stop_limit_start_out <= 1'b0;
        end else begin
            contactor_out <= (state_r == ST_ON) || (state_r == ST_STOPPING)
                          || (state_r == ST_DELAY)
                          || (state_r == ST_FAULT_DROP);
            drive_run_out <= ((state_r == ST_ON) ||
                              (state_r == ST_STOPPING)) &&
                             run_r && !ilock_bad && healthy;
            loop_inhibit_out <= !(((state_r == ST_ON) ||
                                   (state_r == ST_STOPPING)) ||
                                  ((state_r == ST_DELAY) && live_r));
            if (state_r == ST_LOCKOUT)
                lockout_out <= 1'b1;
            else if (state_r == ST_ON)
                lockout_out <= 1'b0;
            if (jog_r && !start_r)
                jog_flag_out <= 1'b1;
            else if (ramp_settled_in || state_r == ST_OFF)
                jog_flag_out <= 1'b0;
            if (jog_r && start_r)
                slack_flag_out <= 1'b1;
            else if (ramp_settled_in || state_r == ST_OFF)
                slack_flag_out <= 1'b0;
            stop_limit_start_out <= start_d_r && !start_r;
        end
    end

    // ============================================================
    // assertions
    sequence s_fault_seen;
        (state_r == ST_ON) && !healthy;
    endsequence
    a_contactor_needs_ready: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(contactor_out) |-> $past(healthy, 2) && $past(demand, 2))
        else $error("contactor energised without conditions");
    a_fault_drop_time: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        s_fault_seen |=> (state_r == ST_FAULT_DROP))
        else $error("fault drop not entered");
    // the drop counter itself bounds the release time
    a_fault_drop_end: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (state_r == ST_FAULT_DROP) && (cnt_r >= 32'(COAST_DROP_CYC - 1))
        |=> state_r == ST_OFF)
        else $error("fault drop timing wrong");
    a_run_low_drop: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (state_r == ST_DELAY) && healthy && !run_r |=> state_r == ST_OFF)
        else $error("run low did not drop contactor");
    a_restart_clears: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (state_r == ST_DELAY) && healthy && run_r && demand
        |=> (state_r == ST_ON) && (cnt_r == 32'h0000_0000))
        else $error("restart did not clear delay");
    a_run_needs_input: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        drive_run_out |-> $past(run_r) && !$past(ilock_bad))
        else $error("drive running without permission");
    a_mode_crawl: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        start_r && !jog_r && sel_r |=> ref_sel_out == 2'(jcs_pkg::REF_CRAWL))
        else $error("crawl decode wrong");
    a_jog_ramp_used: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        jog_r |=> ramp_sel_out == 2'(jcs_pkg::RAMP_JOG))
        else $error("jog ramp not selected");
    a_stop_limit_pulse: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $fell(start_r) |=> stop_limit_start_out ##1 !stop_limit_start_out)
        else $error("stop limit pulse wrong");
    a_delay_inhibit: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $past(state_r == ST_DELAY) && !$past(live_r) |-> loop_inhibit_out)
        else $error("loops not inhibited in delay");
endmodule

// File: operator_terminals.sv
// operator terminal model: start, jog and coast-stop lines
// assumes the bench requests levels; lines change on falling edges
`timescale 1ns/10ps
module operator_terminals #(
    parameter int unsigned LEAD_CYC = 8
) (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic start_req_in,
    input  wire logic jog_req_in,
    input  wire logic coast_req_in,
    output logic      start_out,
    output logic      jog_out,
    output logic      coast_out
);
    int unsigned lead_r;
    always_ff @(negedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lead_r    <= 0;
            start_out <= 1'b0;
            jog_out   <= 1'b0;
            coast_out <= 1'b0;
        end else begin
            coast_out <= coast_req_in;
            lead_r    <= !coast_out ? 0 : (lead_r < LEAD_CYC) ? lead_r + 1
                                                              : lead_r;
            // a raised start stays up; only its rise waits for the lead
            start_out <= start_req_in
                         && (start_out || lead_r >= LEAD_CYC);
            jog_out   <= jog_req_in;
        end
    end
endmodule

// File: testbench.sv
// self-checking bench for the jog / crawl / contactor sequencer
// assumes shortened drop and lockout counts of 20 and 50 cycles
`timescale 1ns/10ps
module testbench;
    logic        clk, rst_n, ws, wj, cq, sel, run, rdy, ien, iok;
    logic        sdone, settled, st, jg, cs, con, drun, inh, lock;
    logic        jflag, sflag, slim;
    logic [2:0]  mode;
    logic [1:0]  rsel, fsel;
    logic [12:0] rtime, jramp;
    logic [13:0] spd, dspd;
    logic [31:0] dly, lfsr_r;
    logic [64:0] corners;
    int          error_cnt, cmp_count, tick, n, i;

    operator_terminals u_ops (.clk_in(clk), .arst_n_in(rst_n),
        .start_req_in(ws), .jog_req_in(wj), .coast_req_in(cq),
        .start_out(st), .jog_out(jg), .coast_out(cs));

    jog_crawl_contactor_sequencer #(.COAST_DROP_CYC(20), .LOCKOUT_CYC(50))
    u_dut (.ref_clk_in(clk), .arst_n_in(rst_n), .start_in(st),
        .jog_in(jg), .select_in(sel), .run_in(run),
        .coast_halt_input_in(cs), .ready_in(rdy), .zero_ilock_en_in(ien),
        .zero_ilock_ok_in(iok), .live_delay_in(1'b0),
        .stop_done_in(sdone), .ramp_settled_in(settled),
        .speed_abs_in(spd), .dropout_speed_in(dspd),
        .dropout_delay_cyc_in(dly), .jog_ramp_in(jramp),
        .contactor_out(con), .drive_run_out(drun),
        .loop_inhibit_out(inh), .lockout_out(lock), .jog_flag_out(jflag),
        .slack_flag_out(sflag), .stop_limit_start_out(slim),
        .mode_out(mode), .ramp_sel_out(rsel), .ref_sel_out(fsel),
        .ramp_time_out(rtime));

    // ==========================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        tick++;
        if (tick == 8000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction
    // expected {mode, ramp, ref} for c = {select, start, jog}
    function automatic logic [6:0] exp_dec(input logic [2:0] c);
        case (c)
            3'h2: return {jcs_pkg::MODE_RUN, jcs_pkg::RAMP_RUN,
                          jcs_pkg::REF_BASE};
            3'h6: return {jcs_pkg::MODE_CRAWL, jcs_pkg::RAMP_RUN,
                          jcs_pkg::REF_CRAWL};
            3'h3: return {jcs_pkg::MODE_SLACK1, jcs_pkg::RAMP_JOG,
                          jcs_pkg::REF_PLUS_SLACK};
            3'h7: return {jcs_pkg::MODE_SLACK2, jcs_pkg::RAMP_JOG,
                          jcs_pkg::REF_PLUS_SLACK};
            3'h1: return {jcs_pkg::MODE_JOG1, jcs_pkg::RAMP_JOG,
                          jcs_pkg::REF_JOG};
            3'h5: return {jcs_pkg::MODE_JOG2, jcs_pkg::RAMP_JOG,
                          jcs_pkg::REF_JOG};
            default: return {jcs_pkg::MODE_STOP, jcs_pkg::RAMP_STOP,
                             jcs_pkg::REF_BASE};
        endcase
    endfunction
    function automatic logic [31:0] exp_ramp(input logic [12:0] v);
        if (v < jcs_pkg::JOG_RAMP_MIN) return jcs_pkg::JOG_RAMP_MIN;
        if (v > jcs_pkg::JOG_RAMP_MAX) return jcs_pkg::JOG_RAMP_MAX;
        return {19'h0_0000, v};
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what,
                     got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_con(input logic v, input int lim);
        int k;
        k = 0;
        while (con !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
        chk(con, v, "contactor");
    endtask
    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count,
                 error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        {ws, wj, cq, sel, run, rdy, ien, iok, sdone, settled} = 10'h000;
        spd = 14'h0000;
        dspd = 14'h2710;
        dly = 32'h0000_0004;
        jramp = 13'h0064;
        lfsr_r = 32'heee5_dc45;
        corners = {13'h0000, 13'h0001, 13'h1770, 13'h1771, 13'h1fff};
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        chk(rtime, 10, "ramp default");
        // ready low refuses the contactor
        {cq, run, sdone, ws} = 4'hf;
        cyc(14);
        chk(con, 0, "not ready");
        rdy = 1'b1;
        wait_con(1'b1, 6);
        $display("test refuse done");
        // every select/start/jog combination
        for (i = 0; i < 8; i++) begin
            {sel, ws, wj} = i[2:0];
            cyc(14);
            chk({mode, rsel, fsel}, exp_dec(i[2:0]), "decode");
            chk(con, ws | wj, "demand");
            chk(drun, ws | wj, "run");
        end
        $display("test decode done");
        // jog ramp time, corners then random
        for (i = 0; i < 24; i++) begin
            lfsr_r = lfsr(lfsr_r);
            jramp = (i < 5) ? corners[64 - 13 * i -: 13] : lfsr_r[12:0];
            cyc(4);
            chk(rtime, exp_ramp(jramp), "ramp time");
        end
        $display("test ramp done");
        // coast-stop drop after a delay, then recovery
        cq = 1'b0;
        cyc(10);
        chk(con, 1, "early drop");
        wait_con(1'b0, 30);
        cq = 1'b1;
        wait_con(1'b1, 30);
        // stop: timer starts at drop speed, restart clears it
        {sdone, spd, dspd, dly} = {1'b0, 14'h1388, 14'h0064, 32'h0000_001e};
        {ws, wj} = 2'h0;
        n = 0;
        repeat (6) @(negedge clk) n += slim;
        chk(n, 1, "stop limit");
        cyc(8);
        chk({con, inh}, 2'h2, "stopping");
        {spd, sdone} = {14'h0032, 1'b1};
        cyc(20);
        chk({con, inh}, 2'h3, "delay");
        ws = 1'b1;
        cyc(5);
        chk({con, inh}, 2'h2, "restart");
        ws = 1'b0;
        cyc(27);
        chk(con, 1, "timer cleared");
        wait_con(1'b0, 15);
        $display("test dropout done");
        // run low mid-stop releases at once
        {ws, spd, sdone} = {1'b1, 14'h1388, 1'b0};
        wait_con(1'b1, 20);
        ws = 1'b0;
        cyc(6);
        run = 1'b0;
        wait_con(1'b0, 4);
        run = 1'b1;
        // jog flag held until the ramp settles
        {wj, spd, sdone} = {1'b1, 14'h0000, 1'b1};
        cyc(6);
        chk({jflag, sflag}, 2'h2, "jog flag");
        {wj, ws} = 2'h1;
        cyc(8);
        chk(jflag, 1, "jog held");
        settled = 1'b1;
        cyc(4);
        chk(jflag, 0, "jog clear");
        ws = 1'b0;
        cyc(20);
        // zero interlock lockout
        {ien, ws} = 2'h3;
        wait_con(1'b1, 10);
        chk(drun, 0, "held off");
        cyc(40);
        chk(con, 1, "lock early");
        wait_con(1'b0, 20);
        chk(lock, 1, "lockout");
        $display("test lockout done");
        end_of_test();
    end
endmodule
